// File: design/fpf_flag_logic.sv
// programmable status-flag logic of a dual-port fifo
// ----------------------------------------
// ----------------------------------------
//
// The plain strobed port and the register addresses were chosen for this implementation.
`default_nettype none
module fpf_flag_logic #(
    parameter int DEPTH = fpf_pkg::FPF_DEPTH,
    parameter int OFS_W = fpf_pkg::FPF_OFS_W
) (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic master_reset_n_i,
    input wire logic offset_load_select_n_i,
    input wire logic default_offset_sel0_i,
    input wire logic default_offset_sel1_i,
    input wire logic flag_timing_mode_select_i,
    input wire logic wclk_edge_i,
    input wire logic wen_i,
    input wire logic rclk_edge_i,
    input wire logic ren_i,
    input wire logic ofs_wr_i,
    input wire logic [OFS_W-1:0] ofs_wdata_i,
    input wire logic ofs_sdata_i,
    input wire logic ofs_rd_i,
    input wire logic [fpf_pkg::FPF_ADDR_W-1:0] bus_addr_i,
    input wire logic [fpf_pkg::FPF_DATA_W-1:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output fpf_pkg::fpf_flags_t flags_o,
    output logic [OFS_W-1:0] parallel_output_port_o,
    output logic [fpf_pkg::FPF_DATA_W-1:0] bus_rdata_o,
    output logic irq_o
);
    import fpf_pkg::*;

    localparam int LVL_W = $clog2(DEPTH) + 1;
    localparam int BCNT_W = $clog2(OFS_W) + 1;
    localparam logic [LVL_W-1:0] LVL_DEPTH = LVL_W'(DEPTH);
    localparam logic [LVL_W-1:0] LVL_HALF = LVL_W'(DEPTH / 2 + 1);

    fpf_cfg_t cfg;
    logic [OFS_W-1:0] empty_ofs;
    logic [OFS_W-1:0] full_ofs;
    logic wr_sel;
    logic rd_sel;
    logic [OFS_W-1:0] shift;
    logic [BCNT_W-1:0] bit_cnt;
    logic [LVL_W-1:0] level;
    logic empty_s1;
    logic full_s1;
    logic [FPF_EV_W-1:0] status;
    logic [FPF_EV_W-1:0] mask;
    logic [2:0] def_idx;
    logic [OFS_W-1:0] def_ofs;
    logic wr_ok;
    logic rd_ok;
    logic lvl_afull;
    logic lvl_aempty;
    logic [FPF_EV_W-1:0] events;
    logic ofs_commit;
    logic [OFS_W-1:0] ofs_value;
    logic [OFS_W-1:0] next_shift;
    logic [LVL_W-1:0] next_level;

    // ----------------------------------------
    // default offset decode
    // ----------------------------------------
    assign def_idx = {offset_load_select_n_i, default_offset_sel0_i, default_offset_sel1_i};
    assign def_ofs = FPF_DEF_OFS[def_idx];

    // ----------------------------------------
    // configuration caught during master reset
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg <= FPF_CFG_RST;
        end else if (!master_reset_n_i) begin
            cfg.serial_load <= offset_load_select_n_i;
            cfg.sync_flags <= flag_timing_mode_select_i;
        end
    end

    // ----------------------------------------
    // offset programming
    // ----------------------------------------
    // serial bits arrive lsb first; a word commits after OFS_W strobes
    assign next_shift = {ofs_sdata_i, shift[OFS_W-1:1]};
    always_comb begin
        ofs_commit = 1'b0;
        ofs_value = ofs_wdata_i;
        if (master_reset_n_i && ofs_wr_i) begin
            if (cfg.serial_load) begin
                ofs_commit = (bit_cnt == BCNT_W'(OFS_W - 1));
                ofs_value = next_shift;
            end else begin
                ofs_commit = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shift <= '0;
            bit_cnt <= '0;
        end else if (!master_reset_n_i) begin
            shift <= '0;
            bit_cnt <= '0;
        end else if (ofs_wr_i && cfg.serial_load) begin
            shift <= next_shift;
            bit_cnt <= ofs_commit ? '0 : bit_cnt + BCNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            empty_ofs <= FPF_DEF_OFS[0];
            full_ofs <= FPF_DEF_OFS[0];
            wr_sel <= 1'b0;
        end else if (!master_reset_n_i) begin
            empty_ofs <= def_ofs;
            full_ofs <= def_ofs;
            wr_sel <= 1'b0;
        end else if (ofs_commit) begin
            // values above D-1 are the writer's fault and are kept as given
            if (!wr_sel) begin
                empty_ofs <= ofs_value;
            end else begin
                full_ofs <= ofs_value;
            end
            wr_sel <= ~wr_sel;
        end
    end

    // readback alternates n then m, in either loading mode
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            parallel_output_port_o <= '0;
            rd_sel <= 1'b0;
        end else if (!master_reset_n_i) begin
            rd_sel <= 1'b0;
        end else if (ofs_rd_i) begin
            parallel_output_port_o <= rd_sel ? full_ofs : empty_ofs;
            rd_sel <= ~rd_sel;
        end
    end

    // ----------------------------------------
    // fill level
    // ----------------------------------------
    assign wr_ok = wclk_edge_i && wen_i && (level != LVL_DEPTH);
    assign rd_ok = rclk_edge_i && ren_i && (level != '0);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level <= '0;
        end else if (!master_reset_n_i) begin
            level <= '0;
        end else begin
            level <= next_level;
        end
    end

    // judged on the count after this edge, so a lone edge settles the flag
    assign next_level = level + LVL_W'(wr_ok) - LVL_W'(rd_ok);
    assign lvl_afull = (next_level >= LVL_DEPTH - LVL_W'(full_ofs));
    assign lvl_aempty = (next_level <= LVL_W'(empty_ofs));

    // ----------------------------------------
    // empty, full and half-full
    // ----------------------------------------
    // two stages for empty and for full, one for half-full; the cost is two edges of flag latency
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            empty_s1 <= 1'b1;
            flags_o.empty_flag_n <= 1'b0;
        end else if (!master_reset_n_i) begin
            empty_s1 <= 1'b1;
            flags_o.empty_flag_n <= 1'b0;
        end else if (rclk_edge_i) begin
            empty_s1 <= (level == '0);
            flags_o.empty_flag_n <= ~empty_s1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            full_s1 <= 1'b0;
            flags_o.full_flag_n <= 1'b1;
        end else if (!master_reset_n_i) begin
            full_s1 <= 1'b0;
            flags_o.full_flag_n <= 1'b1;
        end else if (wclk_edge_i) begin
            full_s1 <= (level == LVL_DEPTH);
            flags_o.full_flag_n <= ~full_s1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_o.half_full_flag_n <= 1'b1;
        end else if (!master_reset_n_i) begin
            flags_o.half_full_flag_n <= 1'b1;
        end else if (wclk_edge_i || rclk_edge_i) begin
            flags_o.half_full_flag_n <= ~(level >= LVL_HALF);
        end
    end

    // ----------------------------------------
    // programmable almost flags
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_o.almost_full_flag_n <= 1'b1;
        end else if (!master_reset_n_i) begin
            flags_o.almost_full_flag_n <= 1'b1;
        end else if (cfg.sync_flags) begin
            if (wclk_edge_i) begin
                flags_o.almost_full_flag_n <= ~lvl_afull;
            end
        end else if (wclk_edge_i && lvl_afull) begin
            flags_o.almost_full_flag_n <= 1'b0;
        end else if (rclk_edge_i && !lvl_afull) begin
            flags_o.almost_full_flag_n <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_o.almost_empty_flag_n <= 1'b0;
        end else if (!master_reset_n_i) begin
            flags_o.almost_empty_flag_n <= 1'b0;
        end else if (cfg.sync_flags) begin
            if (rclk_edge_i) begin
                flags_o.almost_empty_flag_n <= ~lvl_aempty;
            end
        end else if (rclk_edge_i && lvl_aempty) begin
            flags_o.almost_empty_flag_n <= 1'b0;
        end else if (wclk_edge_i && !lvl_aempty) begin
            flags_o.almost_empty_flag_n <= 1'b1;
        end
    end

    // ----------------------------------------
    // interrupt status, mask and register bus
    // ----------------------------------------
    always_comb begin
        events = '0;
        events[FPF_EV_FULL] = flags_o.full_flag_n && wclk_edge_i && full_s1;
        events[FPF_EV_EMPTY] = flags_o.empty_flag_n && rclk_edge_i && empty_s1;
        if (master_reset_n_i) begin
            events[FPF_EV_AFULL] = flags_o.almost_full_flag_n && wclk_edge_i && lvl_afull;
            events[FPF_EV_AEMPTY] = flags_o.almost_empty_flag_n && rclk_edge_i && lvl_aempty;
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status <= '0;
        end else begin
            status <= (status & ~((bus_wr_i && bus_addr_i == FPF_ADR_STATUS)
                ? bus_wdata_i[FPF_EV_W-1:0] : '0)) | events;
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mask <= FPF_MASK_RST;
        end else if (bus_wr_i && bus_addr_i == FPF_ADR_MASK) begin
            mask <= bus_wdata_i[FPF_EV_W-1:0];
        end
    end

    // irq lags the status bit by one cycle to come from a flop
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status & mask);
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus_rdata_o <= '0;
        end else begin
            bus_rdata_o <= '0;
            if (bus_rd_i) begin
                case (bus_addr_i)
                    FPF_ADR_STATUS: bus_rdata_o <= FPF_DATA_W'(status);
                    FPF_ADR_MASK: bus_rdata_o <= FPF_DATA_W'(mask);
                    FPF_ADR_FLAGS: begin
                        bus_rdata_o <= FPF_DATA_W'(flags_o)
                            | (FPF_DATA_W'(level) << FPF_FLG_LVL_LSB);
                    end
                    FPF_ADR_OFFSETS: begin
                        bus_rdata_o <= (FPF_DATA_W'(empty_ofs) << FPF_OFS_N_LSB)
                            | (FPF_DATA_W'(full_ofs) << FPF_OFS_M_LSB);
                    end
                    default: bus_rdata_o <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    AST_DEFAULT_LOAD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !master_reset_n_i |=> empty_ofs == FPF_DEF_OFS[$past(def_idx)]
            && full_ofs == FPF_DEF_OFS[$past(def_idx)])
        else $error("default offsets not loaded at master reset");

    AST_CFG_HOLD: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        master_reset_n_i |=> $stable(cfg))
        else $error("timing or load mode changed outside master reset");

    AST_PAF_SYNC: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        master_reset_n_i && cfg.sync_flags && !wclk_edge_i
            |=> $stable(flags_o.almost_full_flag_n))
        else $error("sync almost-full moved without a write edge");

    AST_PAE_SYNC: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        master_reset_n_i && cfg.sync_flags && !rclk_edge_i
            |=> $stable(flags_o.almost_empty_flag_n))
        else $error("sync almost-empty moved without a read edge");

    AST_PAF_ASYNC: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !cfg.sync_flags && $past(master_reset_n_i) && $changed(flags_o.almost_full_flag_n)
            |-> ($fell(flags_o.almost_full_flag_n) ? $past(wclk_edge_i) : $past(rclk_edge_i)))
        else $error("async almost-full moved on the wrong side");

    AST_PAE_ASYNC: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !cfg.sync_flags && $past(master_reset_n_i) && $changed(flags_o.almost_empty_flag_n)
            |-> ($fell(flags_o.almost_empty_flag_n) ? $past(rclk_edge_i) : $past(wclk_edge_i)))
        else $error("async almost-empty moved on the wrong side");

    AST_EF_TWO_STAGE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        master_reset_n_i && rclk_edge_i && level == '0 ##1 master_reset_n_i && rclk_edge_i
            |=> !flags_o.empty_flag_n)
        else $error("empty flag not low two read edges after empty");

    AST_RD_IGNORED: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        master_reset_n_i && level == '0 && !wr_ok |=> level == '0)
        else $error("level moved on a read while empty");

    AST_OFS_ORDER: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        ofs_commit && !wr_sel |=> empty_ofs == $past(ofs_value) && wr_sel)
        else $error("offset write did not fill n first");

    AST_READBACK: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        master_reset_n_i && ofs_rd_i && rd_sel |=> parallel_output_port_o == $past(full_ofs))
        else $error("full offset not read back");

    AST_PAE_LEVEL: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        master_reset_n_i && cfg.sync_flags && rclk_edge_i && lvl_aempty
            |=> !flags_o.almost_empty_flag_n)
        else $error("almost-empty high at or below offset n");
endmodule
`default_nettype wire

// File: inc/fpf_pkg.sv
// package: constants, tables and carriers of the programmable flag logic
`default_nettype none
package fpf_pkg;
    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int FPF_DEPTH = 512;
    localparam int FPF_OFS_W = 9;
    localparam int FPF_ADDR_W = 4;
    localparam int FPF_DATA_W = 32;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [FPF_ADDR_W-1:0] FPF_ADR_STATUS = 4'h0;
    localparam logic [FPF_ADDR_W-1:0] FPF_ADR_MASK = 4'h4;
    localparam logic [FPF_ADDR_W-1:0] FPF_ADR_FLAGS = 4'h8;
    localparam logic [FPF_ADDR_W-1:0] FPF_ADR_OFFSETS = 4'hC;
    // event bits in status and mask
    localparam int FPF_EV_W = 4;
    localparam int FPF_EV_FULL = 0;
    localparam int FPF_EV_EMPTY = 1;
    localparam int FPF_EV_AFULL = 2;
    localparam int FPF_EV_AEMPTY = 3;
    localparam logic [FPF_EV_W-1:0] FPF_MASK_RST = 4'h0;
    // field positions in the offsets word
    localparam int FPF_OFS_N_LSB = 0;
    localparam int FPF_OFS_M_LSB = 16;
    // field positions in the flags word
    localparam int FPF_FLG_LVL_LSB = 8;
    // ----------------------------------------
    // default offsets, index {load_sel, sel0, sel1}
    // ----------------------------------------
    localparam logic [FPF_OFS_W-1:0] FPF_DEF_OFS [8] = '{
        9'h07F, 9'h1FF, 9'h0FF, 9'h03F, 9'h01F, 9'h00F, 9'h007, 9'h003
    };
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic full_flag_n;
        logic almost_full_flag_n;
        logic half_full_flag_n;
        logic almost_empty_flag_n;
        logic empty_flag_n;
    } fpf_flags_t;
    localparam fpf_flags_t FPF_FLAGS_RST = 5'h1C;
    typedef struct packed {
        logic serial_load;
        logic sync_flags;
    } fpf_cfg_t;
    localparam fpf_cfg_t FPF_CFG_RST = 2'h0;
endpackage
`default_nettype wire

// File: dv/fpf_sys_model.sv
// far-side writer and reader logic, as edge pulses for both ports
`default_nettype none
module fpf_sys_model (
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic free_run_i,
    output logic wclk_edge_o,
    output logic wen_o,
    output logic rclk_edge_o,
    output logic ren_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wreq = 1'b0;
    logic rreq = 1'b0;
    logic [1:0] phase;
    // ----------------------------------------
    // idle edges
    // ----------------------------------------
    // idle edges let the two-stage flags settle; off to isolate one domain
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    assign wclk_edge_o = wreq | (free_run_i & (phase == 2'h1));
    assign wen_o = wreq;
    assign rclk_edge_o = rreq | (free_run_i & (phase == 2'h3));
    assign ren_o = rreq;
    // ----------------------------------------
    // transfers
    // ----------------------------------------
    task automatic push(input int k);
        repeat (k) begin
            @(posedge ref_clk_i);
            wreq <= 1'b1;
            @(posedge ref_clk_i);
            wreq <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask
    // reads at empty are issued as-is; the device must drop them
    task automatic pop(input int k);
        repeat (k) begin
            @(posedge ref_clk_i);
            rreq <= 1'b1;
            @(posedge ref_clk_i);
            rreq <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
        end
    endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench of the programmable flag logic
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fpf_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic mr_n = 1'b1;
    logic ld = 1'b0;
    logic sel0 = 1'b0;
    logic sel1 = 1'b0;
    logic tmode = 1'b1;
    logic free_run = 1'b1;
    logic wclk_edge, wen, rclk_edge, ren, irq;
    logic ofs_wr = 1'b0;
    logic [8:0] ofs_wdata = 9'h000;
    logic ofs_sdata = 1'b0;
    logic ofs_rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    fpf_flags_t flags;
    logic [8:0] port;
    logic [31:0] rdata, d;
    int mismatches = 0;
    int n_checks = 0;
    int lvl = 0;
    int en = 127;
    int em = 127;
    int tgt [9] = '{0, 4, 5, 256, 257, 507, 508, 511, 512};
    logic [8:0] defs [8] = '{9'h07F, 9'h1FF, 9'h0FF, 9'h03F, 9'h01F, 9'h00F, 9'h007, 9'h003};
    logic [8:0] sv = 9'h0A5;
    always #2.5 ref_clk = ~ref_clk;
    fpf_sys_model i_fpf_sys_model (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
        .free_run_i(free_run), .wclk_edge_o(wclk_edge), .wen_o(wen),
        .rclk_edge_o(rclk_edge), .ren_o(ren));
    fpf_flag_logic i_fpf_flag_logic (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
        .master_reset_n_i(mr_n), .offset_load_select_n_i(ld),
        .default_offset_sel0_i(sel0), .default_offset_sel1_i(sel1),
        .flag_timing_mode_select_i(tmode), .wclk_edge_i(wclk_edge), .wen_i(wen),
        .rclk_edge_i(rclk_edge), .ren_i(ren), .ofs_wr_i(ofs_wr), .ofs_wdata_i(ofs_wdata),
        .ofs_sdata_i(ofs_sdata), .ofs_rd_i(ofs_rd), .bus_addr_i(addr), .bus_wdata_i(wdata),
        .bus_wr_i(wr), .bus_rd_i(rd), .flags_o(flags), .parallel_output_port_o(port),
        .bus_rdata_o(rdata), .irq_o(irq));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run();
        if (mismatches == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bw(input logic [3:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic br(input logic [3:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // the stray offset strobe inside master reset must be dropped
    task automatic mrst(input logic [2:0] c, input logic t);
        @(posedge ref_clk);
        {ld, sel0, sel1} <= c;
        tmode <= t;
        mr_n <= 1'b0;
        @(posedge ref_clk);
        ofs_wr <= 1'b1;
        @(posedge ref_clk);
        ofs_wr <= 1'b0;
        @(posedge ref_clk);
        mr_n <= 1'b1;
        @(posedge ref_clk);
        lvl = 0;
        en = int'(defs[c]);
        em = int'(defs[c]);
    endtask
    task automatic ofs_w(input logic [8:0] v, input logic b);
        @(posedge ref_clk);
        ofs_wr <= 1'b1;
        ofs_wdata <= v;
        ofs_sdata <= b;
        @(posedge ref_clk);
        ofs_wr <= 1'b0;
    endtask
    task automatic ofs_r(input logic [8:0] e);
        @(posedge ref_clk);
        ofs_rd <= 1'b1;
        @(posedge ref_clk);
        ofs_rd <= 1'b0;
        #1;
        chk("parallel_output_port_o", 32'(e), 32'(port));
    endtask
    task automatic chk_ofs();
        br(FPF_ADR_OFFSETS, d);
        chk("offsets", {7'h0, 9'(em), 7'h0, 9'(en)}, d);
    endtask
    task automatic chk_lvl();
        fpf_flags_t f;
        repeat (12) @(posedge ref_clk);
        f.full_flag_n = (lvl < FPF_DEPTH);
        f.almost_full_flag_n = (lvl < FPF_DEPTH - em);
        f.half_full_flag_n = (lvl < FPF_DEPTH / 2 + 1);
        f.almost_empty_flag_n = (lvl > en);
        f.empty_flag_n = (lvl > 0);
        br(FPF_ADR_FLAGS, d);
        chk("flags word", {14'h0, 10'(lvl), 3'h0, f}, d);
        chk("flags_o", 32'(f), 32'(flags));
    endtask
    task automatic fill(input int k);
        i_fpf_sys_model.push(k);
        lvl = (lvl + k > FPF_DEPTH) ? FPF_DEPTH : lvl + k;
    endtask
    task automatic drain(input int k);
        i_fpf_sys_model.pop(k);
        lvl = (lvl < k) ? 0 : lvl - k;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        chk("flags_o", 32'h1C, 32'(flags));
        sys_rst <= 1'b0;
        chk_ofs();
        br(FPF_ADR_STATUS, d);
        chk("status", 32'h0, d);
        br(FPF_ADR_MASK, d);
        chk("mask", 32'(FPF_MASK_RST), d);
        br(4'h1, d);
        chk("unmapped", 32'h0, d);
        for (int i = 0; i < 8; i++) begin
            mrst(3'(i), 1'b1);
            chk_ofs();
        end
        mrst(3'h4, 1'b1);
        for (int b = 0; b < 9; b++) begin
            ofs_w(9'h000, sv[b]);
        end
        en = int'(sv);
        chk_ofs();
        mrst(3'h0, 1'b1);
        ofs_w(9'h011, 1'b0);
        ofs_w(9'h022, 1'b0);
        ofs_w(9'h004, 1'b0);
        en = 4;
        em = 34;
        chk_ofs();
        ofs_r(9'h004);
        ofs_r(9'h022);
        ofs_w(9'h004, 1'b0);
        em = 4;
        chk_ofs();
        drain(1);
        chk_lvl();
        for (int i = 0; i < 9; i++) begin
            fill(tgt[i] - lvl);
            chk_lvl();
        end
        fill(1);
        chk_lvl();
        br(FPF_ADR_STATUS, d);
        chk("status", 32'h5, d);
        chk("irq_o", 32'h0, 32'(irq));
        bw(FPF_ADR_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq_o", 32'h1, 32'(irq));
        bw(FPF_ADR_STATUS, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq_o", 32'h0, 32'(irq));
        br(FPF_ADR_STATUS, d);
        chk("status", 32'h4, d);
        free_run <= 1'b0;
        drain(5);
        repeat (12) @(posedge ref_clk);
        chk("almost_full_flag_n", 32'h0, 32'(flags.almost_full_flag_n));
        free_run <= 1'b1;
        chk_lvl();
        mrst(3'h0, 1'b0);
        ofs_w(9'h004, 1'b0);
        ofs_w(9'h004, 1'b0);
        en = 4;
        em = 4;
        fill(508);
        chk_lvl();
        free_run <= 1'b0;
        drain(1);
        repeat (12) @(posedge ref_clk);
        chk("almost_full_flag_n", 32'h1, 32'(flags.almost_full_flag_n));
        drain(503);
        repeat (12) @(posedge ref_clk);
        chk("almost_empty_flag_n", 32'h0, 32'(flags.almost_empty_flag_n));
        fill(1);
        repeat (12) @(posedge ref_clk);
        chk("almost_empty_flag_n", 32'h1, 32'(flags.almost_empty_flag_n));
        free_run <= 1'b1;
        chk_lvl();
        drain(5);
        chk_lvl();
        br(FPF_ADR_STATUS, d);
        chk("status", 32'hE, d);
        complete_run();
    end
endmodule
`default_nettype wire
